// ---- include/rre_pkg.sv ----
// rre_pkg: constants and types for the return and rotate execution block.
// assumes one core clock domain; opcodes come from the core decoder.
package rre_pkg;

  localparam int RRE_PC_W = 12;
  localparam int RRE_DATA_W = 8;
  localparam int RRE_ADDR_W = 8;

  // execution opcodes presented by the decoder
  typedef enum logic [2:0] {
    RRE_OP_NONE = 3'h0,
    RRE_OP_RETURN = 3'h1,
    RRE_OP_RETURN_IMM = 3'h2,
    RRE_OP_RETURN_INT = 3'h3,
    RRE_OP_ROTATE = 3'h4
  } rre_op_t;

  // gray-coded sequence: idle, rotate read, rotate write
  typedef enum logic [1:0] {
    RRE_ST_IDLE = 2'h0,
    RRE_ST_READ = 2'h1,
    RRE_ST_WRITE = 2'h3
  } rre_state_t;

  localparam logic RRE_GIE_RST = 1'b0;
  localparam logic RRE_GIE_ON = 1'b1;
  localparam logic [RRE_DATA_W-1:0] RRE_WREG_RST = 8'h00;
  localparam logic [RRE_PC_W-1:0] RRE_PC_RST = 12'h000;
  localparam logic [RRE_PC_W-1:0] RRE_VEC_RST = 12'h004;

endpackage : rre_pkg

// ---- logic/rre_rotate.sv ----
// rre_rotate: one-bit left rotate of a data byte.
// assumes a combinational use inside the execution block.
module rre_rotate #(
  parameter int W = 8
) (
  input wire logic [W-1:0] data_in, // operand byte
  output logic [W-1:0] data_out // rotated byte
);
  // bit i moves to bit i+1, top bit wraps to bit 0
  assign data_out = {data_in[W-2:0], data_in[W-1]};
endmodule : rre_rotate

// ---- logic/rre_exec.sv ----
// rre_exec: execution of subroutine return, return with immediate,
// return from interrupt and rotate-left of a data memory byte.
// assumes the stack pops in one cycle and memory reads answer next cycle.
// ***************************************************************
// Operation
// - return with immediate pops the stack into the program counter.
// - return with immediate loads its immediate into the working register.
// - return from interrupt pops the stack and sets global enable unless a request is pending.
// - global enable gates every interrupt source of the core, except a request pending at return from interrupt.
// - a pending request after return from interrupt is vectored first.
// - rotate left moves bit i to i+1 and bit 7 to bit 0.
// - neither return form changes any status flag.
// - plain return restores the counter and leaves flags unchanged.
// ***************************************************************
module rre_exec
  import rre_pkg::*;
#(
  parameter int PC_W = RRE_PC_W,
  parameter logic [RRE_PC_W-1:0] INT_VECTOR = RRE_VEC_RST
) (
  input wire logic clk_sys_in, // core clock, 25 MHz
  input wire logic sys_rst_in, // synchronous reset, active high
  input wire logic op_valid_in, // decoder presents an instruction
  input wire rre_op_t op_code_in, // instruction kind
  input wire logic [RRE_DATA_W-1:0] op_imm_in, // immediate operand
  input wire logic [RRE_ADDR_W-1:0] op_addr_in, // data memory address
  input wire logic [PC_W-1:0] stack_top_in, // top of return stack
  input wire logic [RRE_DATA_W-1:0] mem_rdata_in, // memory read data
  input wire logic int_req_in, // any interrupt source requesting
  input wire logic [RRE_DATA_W-1:0] status_in, // current status flags
  input wire logic gie_clr_in, // core clears global enable
  output logic op_ready_out, // block can take an instruction
  output logic stack_pop_out, // pop pulse to return stack
  output logic stack_push_out, // push pulse on vectoring
  output logic [PC_W-1:0] stack_wdata_out, // address pushed on vectoring
  output logic pc_load_out, // load pulse for program counter
  output logic [PC_W-1:0] pc_value_out, // new program counter
  output logic [RRE_DATA_W-1:0] working_register_out, // working register
  output logic global_interrupt_enable_out, // master interrupt enable
  output logic int_take_out, // interrupt accepted pulse
  output logic [RRE_DATA_W-1:0] status_out, // status flags written back
  output logic mem_rd_out, // memory read strobe
  output logic mem_wr_out, // memory write strobe
  output logic [RRE_ADDR_W-1:0] mem_addr_out, // memory address
  output logic [RRE_DATA_W-1:0] mem_wdata_out // memory write data
);

  typedef struct packed {
    rre_state_t st;
    logic gie;
    logic [RRE_DATA_W-1:0] wreg;
    logic [RRE_DATA_W-1:0] stat;
    logic [RRE_ADDR_W-1:0] addr;
    logic [RRE_DATA_W-1:0] wdata;
    logic rd;
    logic wr;
    logic pop;
    logic push;
    logic take;
    logic pcld;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] back_pc;
  } rre_regs_t;

  rre_regs_t q_r;
  rre_regs_t q_nxt;
  logic [RRE_DATA_W-1:0] rot_w;
  logic int_gate_w;

  rre_rotate #(.W(RRE_DATA_W)) u_rot (
    .data_in(mem_rdata_in),
    .data_out(rot_w)
  );

  // ***************************************************************
  // interrupt gating
  // ***************************************************************
  assign int_gate_w = int_req_in && q_r.gie;

  always_comb begin
    q_nxt = q_r;
    q_nxt.rd = 1'b0;
    q_nxt.wr = 1'b0;
    q_nxt.pop = 1'b0;
    q_nxt.push = 1'b0;
    q_nxt.take = 1'b0;
    q_nxt.pcld = 1'b0;
    q_nxt.stat = status_in;
    if (gie_clr_in) begin
      q_nxt.gie = RRE_GIE_RST;
    end
    case (q_r.st)
      RRE_ST_IDLE: begin
        if (op_valid_in && !q_r.pop) begin
          case (op_code_in)
            RRE_OP_RETURN: begin
              q_nxt.pop = 1'b1;
              q_nxt.pcld = 1'b1;
              q_nxt.pc = stack_top_in;
            end
            RRE_OP_RETURN_IMM: begin
              q_nxt.pop = 1'b1;
              q_nxt.pcld = 1'b1;
              q_nxt.pc = stack_top_in;
              q_nxt.wreg = op_imm_in;
            end
            RRE_OP_RETURN_INT: begin
              q_nxt.pop = 1'b1;
              q_nxt.gie = RRE_GIE_ON;
              if (int_req_in) begin
                // pending request: keep popped address, go to vector
                q_nxt.push = 1'b1;
                q_nxt.take = 1'b1;
                q_nxt.back_pc = stack_top_in;
                q_nxt.gie = RRE_GIE_RST;
                q_nxt.pc = INT_VECTOR;
              end else begin
                q_nxt.pc = stack_top_in;
              end
              q_nxt.pcld = 1'b1;
            end
            RRE_OP_ROTATE: begin
              q_nxt.rd = 1'b1;
              q_nxt.addr = op_addr_in;
              q_nxt.st = RRE_ST_READ;
            end
            default: begin
            end
          endcase
        end else if (int_gate_w && !op_valid_in) begin
          q_nxt.take = 1'b1;
          q_nxt.gie = RRE_GIE_RST;
        end
      end
      RRE_ST_READ: begin
        q_nxt.st = RRE_ST_WRITE;
      end
      RRE_ST_WRITE: begin
        q_nxt.wr = 1'b1;
        q_nxt.wdata = rot_w;
        q_nxt.st = RRE_ST_IDLE;
      end
      default: begin
        q_nxt.st = RRE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      q_r <= '{st: RRE_ST_IDLE, gie: RRE_GIE_RST, wreg: RRE_WREG_RST,
               stat: RRE_WREG_RST, addr: '0, wdata: RRE_WREG_RST, rd: 1'b0,
               wr: 1'b0, pop: 1'b0, push: 1'b0, take: 1'b0, pcld: 1'b0,
               pc: RRE_PC_RST, back_pc: RRE_PC_RST};
    end else begin
      q_r <= q_nxt;
    end
  end

  // a pop reaches the stack one edge late: hold off the next return until the top is fresh
  assign op_ready_out = (q_r.st == RRE_ST_IDLE) && !q_r.pop;
  assign stack_pop_out = q_r.pop;
  assign stack_push_out = q_r.push;
  assign stack_wdata_out = q_r.back_pc;
  assign pc_load_out = q_r.pcld;
  assign pc_value_out = q_r.pc;
  assign working_register_out = q_r.wreg;
  assign global_interrupt_enable_out = q_r.gie;
  assign int_take_out = q_r.take;
  assign status_out = q_r.stat;
  assign mem_rd_out = q_r.rd;
  assign mem_wr_out = q_r.wr;
  assign mem_addr_out = q_r.addr;
  assign mem_wdata_out = q_r.wdata;

  // ***************************************************************
  // assertions
  // ***************************************************************
  logic idle_w;
  assign idle_w = op_ready_out && op_valid_in;

  property p_return_imm_pop;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    idle_w && op_code_in == RRE_OP_RETURN_IMM |=> stack_pop_out && pc_load_out
      && pc_value_out == $past(stack_top_in);
  endproperty
  a_return_imm_pop: assert property (p_return_imm_pop) else $error("return imm pc");

  property p_return_imm_wreg;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    idle_w && op_code_in == RRE_OP_RETURN_IMM |=> working_register_out == $past(op_imm_in);
  endproperty
  a_return_imm_wreg: assert property (p_return_imm_wreg) else $error("imm load");

  // a clear in the same cycle must lose against the set
  property p_return_int_gie;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    idle_w && op_code_in == RRE_OP_RETURN_INT && !int_req_in
      |=> stack_pop_out && global_interrupt_enable_out && pc_value_out == $past(stack_top_in);
  endproperty
  a_return_int_gie: assert property (p_return_int_gie) else $error("enable not set");

  property p_gate;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    int_take_out |-> $past(int_req_in)
      && ($past(global_interrupt_enable_out) || stack_push_out);
  endproperty
  a_gate: assert property (p_gate) else $error("ungated take");

  property p_return_int_pend;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    idle_w && op_code_in == RRE_OP_RETURN_INT && int_req_in
      |=> int_take_out && stack_push_out && pc_value_out == INT_VECTOR
      && stack_wdata_out == $past(stack_top_in);
  endproperty
  a_return_int_pend: assert property (p_return_int_pend) else $error("pending vector");

  property p_rotate;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    idle_w && op_code_in == RRE_OP_ROTATE ##2 1'b1 |=> mem_wr_out
      && mem_wdata_out == {$past(mem_rdata_in[6:0]), $past(mem_rdata_in[7])};
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate data");

  property p_flags;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    idle_w && op_code_in inside {RRE_OP_RETURN_INT, RRE_OP_RETURN_IMM}
      |=> status_out == $past(status_in);
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed");

  property p_return;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    idle_w && op_code_in == RRE_OP_RETURN |=> pc_load_out
      && pc_value_out == $past(stack_top_in) && status_out == $past(status_in);
  endproperty
  a_return: assert property (p_return) else $error("plain return");

  property p_same_addr;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    idle_w && op_code_in == RRE_OP_ROTATE |=> mem_rd_out ##2 mem_wr_out
      && mem_addr_out == $past(op_addr_in, 3);
  endproperty
  a_same_addr: assert property (p_same_addr) else $error("rotate address");

  c_return_imm: cover property (@(posedge clk_sys_in) idle_w
    && op_code_in == RRE_OP_RETURN_IMM);
  c_return_int_pend: cover property (@(posedge clk_sys_in) idle_w
    && op_code_in == RRE_OP_RETURN_INT && int_req_in);
  c_rotate: cover property (@(posedge clk_sys_in) mem_wr_out);

endmodule : rre_exec

// ---- bench/rre_partner.sv ----
// rre_partner: return stack and data memory facing the execution block.
// assumes one-cycle pulses from the block on the core clock.
module rre_partner
  import rre_pkg::*;
(
  input wire logic clk_in, // core clock
  input wire logic pop_in, // stack pop pulse
  input wire logic push_in, // stack push pulse
  input wire logic [RRE_PC_W-1:0] push_data_in, // pushed address
  output logic [RRE_PC_W-1:0] top_out, // top of stack
  input wire logic rd_in, // memory read pulse
  input wire logic wr_in, // memory write pulse
  input wire logic [RRE_ADDR_W-1:0] addr_in, // memory address
  input wire logic [RRE_DATA_W-1:0] wdata_in, // memory write data
  output logic [RRE_DATA_W-1:0] rdata_out // memory read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [RRE_PC_W-1:0] stk [32];
  logic [RRE_DATA_W-1:0] mem [256];
  int sp = 32;
  initial begin
    rdata_out = 8'h00;
    for (int i = 0; i < 256; i++) begin
      if (i < 32) stk[i] = RRE_PC_W'(i * 97 + 5);
      mem[i] = RRE_DATA_W'(i * 37 + 11);
    end
  end
  assign top_out = stk[sp - 1];
  always @(posedge clk_in) begin
    if (pop_in && push_in) stk[sp - 1] <= push_data_in;
    else if (pop_in) sp <= sp - 1;
    else if (push_in) begin
      stk[sp] <= push_data_in;
      sp <= sp + 1;
    end
    // data is only valid the cycle after a read, then it keeps flipping
    if (rd_in) rdata_out <= mem[addr_in];
    else rdata_out <= ~rdata_out;
    if (wr_in) mem[addr_in] <= wdata_in;
  end
endmodule : rre_partner

// ---- bench/test_return_and_rotate_exec.sv ----
// test_return_and_rotate_exec: self-checking bench of the execution block.
// assumes rre_partner stands in for the return stack and data memory.
module test_return_and_rotate_exec
  import rre_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, op_valid_in = 1'b0, int_req_in = 1'b0;
  logic gie_clr_in = 1'b0;
  rre_op_t op_code_in = RRE_OP_NONE;
  logic [7:0] op_imm_in = 8'h00, op_addr_in = 8'h00, status_in = 8'h00, mem_rdata_in;
  logic [11:0] stack_top_in, stack_wdata_out, pc_value_out, sv;
  logic op_ready_out, stack_pop_out, stack_push_out, pc_load_out, int_take_out;
  logic global_interrupt_enable_out, mem_rd_out, mem_wr_out, gie_e = 1'b0;
  logic [7:0] working_register_out, status_out, mem_addr_out, mem_wdata_out, wreg_e = 8'h00;
  logic [23:0] exp_q [$];
  int mismatches = 0, num_checks = 0;
  logic [1:0] rd_h = 2'h0;
  always #20 clk_sys_in = ~clk_sys_in;
  rre_exec i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .op_valid_in(op_valid_in),
    .op_code_in(op_code_in), .op_imm_in(op_imm_in), .op_addr_in(op_addr_in),
    .stack_top_in(stack_top_in), .mem_rdata_in(mem_rdata_in), .int_req_in(int_req_in),
    .status_in(status_in), .gie_clr_in(gie_clr_in), .op_ready_out(op_ready_out),
    .stack_pop_out(stack_pop_out), .stack_push_out(stack_push_out),
    .stack_wdata_out(stack_wdata_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
    .working_register_out(working_register_out),
    .global_interrupt_enable_out(global_interrupt_enable_out), .int_take_out(int_take_out),
    .status_out(status_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out));
  rre_partner i_part (.clk_in(clk_sys_in), .pop_in(stack_pop_out), .push_in(stack_push_out),
    .push_data_in(stack_wdata_out), .top_out(stack_top_in), .rd_in(mem_rd_out),
    .wr_in(mem_wr_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .rdata_out(mem_rdata_in));
  // ***************************************************************
  // checking and closing
  // ***************************************************************
  task chk(input logic [23:0] act, input logic [23:0] exp);
    num_checks++;
    if (act !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : chk
  task final_report;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // holds the request until taken, then notes the expected result
  task do_op(input rre_op_t c, input logic [7:0] imm, input logic [7:0] adr);
    int n;
    logic [7:0] m;
    op_code_in <= c;
    op_imm_in <= imm;
    op_addr_in <= adr;
    op_valid_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (op_ready_out !== 1'b1 && n < 20);
    if (op_ready_out !== 1'b1) mismatches++;
    m = i_part.mem[adr];
    if (c == RRE_OP_ROTATE) exp_q.push_back({2'h2, 4'h3, adr, m[6:0], m[7], 2'h0});
    else if (c == RRE_OP_RETURN_INT && int_req_in) begin
      gie_e = 1'b0;
      exp_q.push_back({2'h1, RRE_VEC_RST, wreg_e, 1'b0, 1'b1});
    end else begin
      if (c == RRE_OP_RETURN_INT) gie_e = 1'b1;
      if (c == RRE_OP_RETURN_IMM) wreg_e = imm;
      exp_q.push_back({2'h1, stack_top_in, wreg_e, gie_e, 1'b0});
    end
  endtask : do_op
  always @(posedge clk_sys_in) status_in <= 8'($urandom);
  always @(posedge clk_sys_in) begin : mon
    logic [7:0] s;
    logic r;
    s = status_in;
    r = sys_rst_in;
    #1;
    if (!r) begin
      chk(24'(status_out), 24'(s));
      if (pc_load_out === 1'b1) chk({op_ready_out, stack_pop_out, pc_value_out,
        working_register_out, global_interrupt_enable_out, stack_push_out},
        exp_q.pop_front());
      if (mem_wr_out === 1'b1)
        chk({2'h2, 2'h0, op_ready_out, rd_h[1], mem_addr_out, mem_wdata_out, 2'h0},
          exp_q.pop_front());
    end
    // read strobe history, so the write can prove its read came two cycles earlier
    rd_h = {rd_h[0], mem_rd_out};
  end
  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    void'($urandom(24068));
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk(24'({global_interrupt_enable_out, working_register_out}),
      24'({RRE_GIE_RST, RRE_WREG_RST}));
    @(posedge clk_sys_in);
    do_op(RRE_OP_RETURN_IMM, 8'($urandom), 8'h00);
    do_op(RRE_OP_RETURN_IMM, 8'hFF, 8'h00);
    do_op(RRE_OP_RETURN, 8'h5A, 8'h00);
    do_op(RRE_OP_RETURN_INT, 8'h00, 8'h00);
    do_op(RRE_OP_RETURN_IMM, 8'h00, 8'h00);
    do_op(RRE_OP_ROTATE, 8'h00, 8'h00);
    do_op(RRE_OP_ROTATE, 8'h00, 8'hFF);
    do_op(RRE_OP_ROTATE, 8'h00, (8'($urandom) & 8'h1F) | 8'h20);
    do_op(RRE_OP_RETURN, 8'h00, 8'h00);
    op_valid_in <= 1'b0;
    int_req_in <= 1'b1;
    @(posedge clk_sys_in);
    int_req_in <= 1'b0;
    #1;
    chk(24'({int_take_out, global_interrupt_enable_out}), 24'h2);
    gie_e = 1'b0;
    @(posedge clk_sys_in);
    int_req_in <= 1'b1;
    @(posedge clk_sys_in);
    int_req_in <= 1'b0;
    #1;
    chk(24'(int_take_out), 24'h0);
    @(posedge clk_sys_in);
    int_req_in <= 1'b1;
    do_op(RRE_OP_RETURN_INT, 8'h00, 8'h00);
    sv = stack_top_in;
    int_req_in <= 1'b0;
    op_valid_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk(24'(stack_top_in), 24'(sv));
    do_op(RRE_OP_RETURN, 8'h00, 8'h00);
    // clear and return from interrupt in one cycle: the set must win
    gie_clr_in <= 1'b1;
    do_op(RRE_OP_RETURN_INT, 8'h00, 8'h00);
    op_valid_in <= 1'b0;
    @(posedge clk_sys_in);
    gie_clr_in <= 1'b0;
    #1;
    chk(24'(global_interrupt_enable_out), 24'h0);
    repeat (4) @(posedge clk_sys_in);
    chk(24'(exp_q.size()), 24'h0);
    final_report();
  end
  initial begin
    repeat (2000) @(posedge clk_sys_in);
    mismatches++;
    final_report();
  end
endmodule : test_return_and_rotate_exec
